//--- pkg/peda_cfg.svh
`ifndef PEDA_CFG_SVH
`define PEDA_CFG_SVH
// register byte offsets
`define PEDA_OFF_CSR 8'h00
`define PEDA_OFF_MIRROR 8'h04
`define PEDA_OFF_STAT_SET 8'h08
`define PEDA_OFF_STAT_CLR 8'h0c
`define PEDA_OFF_HOST_EN 8'h10
`define PEDA_OFF_LOCAL_EN 8'h14
`define PEDA_OFF_CTRL 8'h18
// command_status_reg fields
`define PEDA_CSR_PAR_RESP 6
`define PEDA_CSR_SYSTEM_ERROR_PIN_ENABLE 8
`define PEDA_CSR_MDP 24
`define PEDA_CSR_STA 27
`define PEDA_CSR_RTA 28
`define PEDA_CSR_RMA 29
`define PEDA_CSR_SSE 30
`define PEDA_CSR_DPE 31
// internal error flag vector positions
`define PEDA_FLG_MDP 0
`define PEDA_FLG_STA 1
`define PEDA_FLG_RTA 2
`define PEDA_FLG_RMA 3
`define PEDA_FLG_SSE 4
`define PEDA_FLG_DPE 5
// internal status register fields
`define PEDA_ST_SOFT 0
`define PEDA_ST_PAR 1
`define PEDA_ST_SYS 2
`define PEDA_ST_MAB 3
`define PEDA_ST_TAB 4
// control register fields
`define PEDA_CTRL_SOFT_RST 0
`define PEDA_CTRL_HALTED 1
`define PEDA_CTRL_BUSY 2
// reset values
`define PEDA_FLG_RST 6'h00
`define PEDA_STAT_RST 5'h00
// link-clock counts
`define PEDA_DEVSEL_TMO 3'h5
`define PEDA_PERR_HOLD 2'h2
`endif

//--- pkg/peda_pkg.sv
`default_nettype none
package peda_pkg;
    typedef enum logic [2:0] {
        PEDA_M_IDLE,
        PEDA_M_ADDR,
        PEDA_M_DATA,
        PEDA_M_LAST,
        PEDA_M_TURN,
        PEDA_M_FLUSH
    } peda_mst_st_t;
endpackage : peda_pkg
`default_nettype wire

//--- logic/peda_sync.sv
`default_nettype none
module peda_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule : peda_sync
`default_nettype wire

//--- logic/peda_core.sv
`include "peda_cfg.svh"
`default_nettype none
// Operation
// RULE_01 - the host supplies the link clock at no more than 66 MHz
// RULE_02 - word accesses start at byte addresses with two low bits 00
// RULE_03 - halfword accesses start at byte addresses with low bit 0
// RULE_04 - target side takes any byte address; master transfers start word aligned
// RULE_05 - master sets master data parity flag on bad read parity or target error
// RULE_06 - detected parity flag on master read, target write or address parity error
// RULE_07 - parity error line driven only with response enable and detected flag set
// RULE_08 - parity error line held until the second link clock after the error
// RULE_09 - parity errors never abort; transfer completes unless a disconnect occurs
// RULE_10 - system flag on address parity error, error line seen, or target abort; address parity errors count only with parity response enabled
// RULE_11 - system error line driven only with pin enable and system flag set
// RULE_12 - after system error the interface halts until software or hardware reset
// RULE_13 - driving system error sets the signaled system error flag
// RULE_14 - master abort releases frame, keeps irdy, readies requester to burst end
// RULE_15 - master abort sets received master abort in register and mirror
// RULE_16 - target abort ends like master abort and sets received target abort
// RULE_17 - retry or disconnect reissues from first untransferred word
// RULE_18 - retries and disconnects stay invisible to the internal requester
// RULE_19 - target abort issued by the device raises the target abort event
// RULE_20 - events raise host and local interrupts under per-event enables
// RULE_21 - error flags set only by hardware; writing one clears them
// RULE_22 - reset clears all error flags, system flag and the halt
module peda_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pci_clk_line,
    input wire logic [31:0] ad_line_in,
    input wire logic [3:0] cbe_line_in_n,
    input wire logic par_line_in,
    input wire logic frame_line_in_n,
    input wire logic initiator_ready_line_in_n,
    input wire logic target_ready_line_in_n,
    input wire logic stop_line_in_n,
    input wire logic devsel_line_in_n,
    input wire logic parity_error_line_in_n,
    output logic frame_line_out_n,
    output logic frame_line_oe,
    output logic initiator_ready_line_out_n,
    output logic initiator_ready_line_oe,
    output logic parity_error_line_out_n,
    output logic parity_error_line_oe,
    output logic system_error_line_out_n,
    output logic system_error_line_oe,
    output logic inta_line_out_n,
    output logic inta_line_oe,
    input wire logic slv_active,
    input wire logic slv_write,
    input wire logic slv_target_abort,
    input wire logic mst_req,
    input wire logic [31:0] mst_addr,
    input wire logic mst_write,
    input wire logic [8:0] mst_words,
    output logic mst_ready,
    output logic mst_done,
    output logic mst_busy,
    output logic [31:0] mst_cur_addr,
    output logic local_int
);
    logic [43:0] pin_s;
    logic clk_s, par_s, frame_s, irdy_s, trdy_s, stop_s, devsel_s, perr_s;
    logic [31:0] ad_s;
    logic [3:0] cbe_s;

    // link pins are sampled by pclk; a 125 MHz pclk resolves link edges only below 62.5 MHz
    peda_sync #(.W(44)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({pci_clk_line, ad_line_in, ~cbe_line_in_n, par_line_in, ~frame_line_in_n,
            ~initiator_ready_line_in_n, ~target_ready_line_in_n, ~stop_line_in_n,
            ~devsel_line_in_n, ~parity_error_line_in_n}),
        .q(pin_s)
    );
    assign {clk_s, ad_s, cbe_s, par_s, frame_s, irdy_s, trdy_s, stop_s, devsel_s, perr_s} = pin_s;

    // link-edge history
    logic clk_q_r, frame_p_r, frame_pp_r, dph_p_r, mrd_p_r, swr_p_r;
    logic [31:0] ad_p_r;
    logic [3:0] cbe_p_r;
    logic pe;
    assign pe = clk_s & ~clk_q_r;

    // master engine
    peda_pkg::peda_mst_st_t st_r, st_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic [2:0] tmo_r, tmo_nxt;
    logic wr_r, wr_nxt, seen_r, seen_nxt, abt_r, abt_nxt;
    logic frame_r, frame_nxt, irdy_r, irdy_nxt, rdy_r, rdy_nxt, done_r, done_nxt;
    logic mabt_ev, tabt_ev, mastering;

    // error and register state
    logic [5:0] flg_r, flg_nxt, flg_set, flg_clr;
    logic [4:0] stat_r, stat_nxt, stat_ev, hien_r, hien_nxt, lien_r, lien_nxt;
    logic pre_r, pre_nxt, sen_r, sen_nxt, sys_r, sys_nxt, halted_r, halted_nxt;
    logic [1:0] perr_cnt_r, perr_cnt_nxt;
    logic [31:0] prdata_r, prdata_nxt, csr_rd;
    logic local_int_r, local_int_nxt;
    logic perr_chk, addr_perr, data_perr_m, data_perr_s, perr_seen, serr_drv;
    logic wr_acc, soft_rst, mapped;

    assign mastering = (st_r == peda_pkg::PEDA_M_DATA) || (st_r == peda_pkg::PEDA_M_LAST);
    // even parity over AD and C/BE of the previous link cycle
    assign perr_chk = par_s != ^{ad_p_r, cbe_p_r};
    assign addr_perr = pe && frame_p_r && !frame_pp_r && perr_chk;
    assign data_perr_m = pe && dph_p_r && mrd_p_r && perr_chk;
    assign data_perr_s = pe && dph_p_r && swr_p_r && perr_chk;
    assign perr_seen = pe && perr_s && mastering && wr_r;
    assign serr_drv = sen_r && sys_r; // RULE_11

    always_comb begin
        st_nxt = st_r;
        addr_nxt = addr_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        tmo_nxt = tmo_r;
        seen_nxt = seen_r;
        abt_nxt = abt_r;
        frame_nxt = frame_r;
        irdy_nxt = irdy_r;
        rdy_nxt = 1'b0;
        done_nxt = 1'b0;
        mabt_ev = 1'b0;
        tabt_ev = 1'b0;
        case (st_r)
            peda_pkg::PEDA_M_IDLE: begin
                abt_nxt = 1'b0;
                // unaligned requests are never started
                if (pe && mst_req && !halted_r && mst_addr[1:0] == 2'h0
                        && mst_words != 9'h000) begin // RULE_02 RULE_03 RULE_04
                    addr_nxt = mst_addr;
                    cnt_nxt = mst_words;
                    wr_nxt = mst_write;
                    frame_nxt = 1'b1;
                    st_nxt = peda_pkg::PEDA_M_ADDR;
                end
            end
            peda_pkg::PEDA_M_ADDR: begin
                if (pe) begin
                    irdy_nxt = 1'b1;
                    frame_nxt = cnt_r > 9'h001;
                    tmo_nxt = 3'h0;
                    seen_nxt = 1'b0;
                    st_nxt = peda_pkg::PEDA_M_DATA;
                end
            end
            peda_pkg::PEDA_M_DATA: begin
                // parity results never feed this decision
                if (pe) begin // RULE_09
                    if (devsel_s) begin
                        seen_nxt = 1'b1;
                    end
                    if (!devsel_s && !seen_r) begin
                        tmo_nxt = tmo_r + 3'h1;
                        if (tmo_nxt == `PEDA_DEVSEL_TMO) begin // RULE_14
                            mabt_ev = 1'b1;
                            abt_nxt = 1'b1;
                            frame_nxt = 1'b0;
                            st_nxt = peda_pkg::PEDA_M_LAST;
                        end
                    end else if (stop_s && !devsel_s) begin // RULE_16
                        tabt_ev = 1'b1;
                        abt_nxt = 1'b1;
                        frame_nxt = 1'b0;
                        st_nxt = peda_pkg::PEDA_M_LAST;
                    end else begin
                        if (trdy_s) begin
                            rdy_nxt = 1'b1;
                            addr_nxt = addr_r + 32'h4;
                            cnt_nxt = cnt_r - 9'h001;
                            frame_nxt = cnt_r > 9'h002;
                        end
                        if (trdy_s && cnt_r == 9'h001) begin
                            irdy_nxt = 1'b0;
                            st_nxt = peda_pkg::PEDA_M_TURN;
                        end else if (stop_s) begin // RULE_18
                            frame_nxt = 1'b0;
                            st_nxt = peda_pkg::PEDA_M_LAST;
                        end
                    end
                end
            end
            peda_pkg::PEDA_M_LAST: begin
                if (pe) begin
                    irdy_nxt = 1'b0;
                    st_nxt = abt_r ? peda_pkg::PEDA_M_FLUSH : peda_pkg::PEDA_M_TURN;
                end
            end
            peda_pkg::PEDA_M_TURN: begin
                if (pe) begin
                    if (cnt_r != 9'h000) begin // RULE_17
                        frame_nxt = 1'b1;
                        st_nxt = peda_pkg::PEDA_M_ADDR;
                    end else begin
                        done_nxt = 1'b1;
                        st_nxt = peda_pkg::PEDA_M_IDLE;
                    end
                end
            end
            peda_pkg::PEDA_M_FLUSH: begin
                // requester still sees one ready per remaining word
                if (cnt_r != 9'h000) begin // RULE_14
                    rdy_nxt = 1'b1;
                    cnt_nxt = cnt_r - 9'h001;
                end else begin
                    done_nxt = 1'b1;
                    st_nxt = peda_pkg::PEDA_M_IDLE;
                end
            end
            default: st_nxt = peda_pkg::PEDA_M_IDLE;
        endcase
        // a halt drops the bus at once and drains the requester
        if (halted_r && st_r != peda_pkg::PEDA_M_IDLE
                && st_r != peda_pkg::PEDA_M_FLUSH) begin // RULE_12
            frame_nxt = 1'b0;
            irdy_nxt = 1'b0;
            rdy_nxt = 1'b0;
            st_nxt = peda_pkg::PEDA_M_FLUSH;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= peda_pkg::PEDA_M_IDLE;
            addr_r <= 32'h0;
            cnt_r <= 9'h000;
            tmo_r <= 3'h0;
            wr_r <= 1'b0;
            seen_r <= 1'b0;
            abt_r <= 1'b0;
            frame_r <= 1'b0;
            irdy_r <= 1'b0;
            rdy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            addr_r <= addr_nxt;
            cnt_r <= cnt_nxt;
            tmo_r <= tmo_nxt;
            wr_r <= wr_nxt;
            seen_r <= seen_nxt;
            abt_r <= abt_nxt;
            frame_r <= frame_nxt;
            irdy_r <= irdy_nxt;
            rdy_r <= rdy_nxt;
            done_r <= done_nxt;
        end
    end

    // apb: zero wait states, read data captured in the setup cycle
    assign wr_acc = psel && penable && pwrite;
    assign soft_rst = wr_acc && paddr == `PEDA_OFF_CTRL && pwdata[`PEDA_CTRL_SOFT_RST];
    assign mapped = paddr <= `PEDA_OFF_CTRL && paddr[1:0] == 2'h0;

    always_comb begin
        csr_rd = 32'h0;
        csr_rd[`PEDA_CSR_PAR_RESP] = pre_r;
        csr_rd[`PEDA_CSR_SYSTEM_ERROR_PIN_ENABLE] = sen_r;
        csr_rd[`PEDA_CSR_MDP] = flg_r[`PEDA_FLG_MDP];
        csr_rd[`PEDA_CSR_STA] = flg_r[`PEDA_FLG_STA];
        csr_rd[`PEDA_CSR_RTA] = flg_r[`PEDA_FLG_RTA];
        csr_rd[`PEDA_CSR_RMA] = flg_r[`PEDA_FLG_RMA];
        csr_rd[`PEDA_CSR_SSE] = flg_r[`PEDA_FLG_SSE];
        csr_rd[`PEDA_CSR_DPE] = flg_r[`PEDA_FLG_DPE];
        flg_set = 6'h00;
        flg_set[`PEDA_FLG_MDP] = data_perr_m || perr_seen; // RULE_05
        flg_set[`PEDA_FLG_DPE] = data_perr_m || data_perr_s || addr_perr; // RULE_06
        flg_set[`PEDA_FLG_RMA] = mabt_ev; // RULE_15
        flg_set[`PEDA_FLG_RTA] = tabt_ev; // RULE_16
        flg_set[`PEDA_FLG_STA] = slv_target_abort;
        flg_set[`PEDA_FLG_SSE] = serr_drv; // RULE_13
        flg_clr = 6'h00;
        if (wr_acc && paddr == `PEDA_OFF_CSR) begin
            flg_clr = {pwdata[`PEDA_CSR_DPE], pwdata[`PEDA_CSR_SSE], pwdata[`PEDA_CSR_RMA],
                       pwdata[`PEDA_CSR_RTA], pwdata[`PEDA_CSR_STA], pwdata[`PEDA_CSR_MDP]};
        end
        // hardware set wins over a same-cycle clear
        flg_nxt = flg_set | (flg_r & ~flg_clr); // RULE_21
        pre_nxt = (wr_acc && paddr == `PEDA_OFF_CSR) ? pwdata[`PEDA_CSR_PAR_RESP] : pre_r;
        sen_nxt = (wr_acc && paddr == `PEDA_OFF_CSR) ? pwdata[`PEDA_CSR_SYSTEM_ERROR_PIN_ENABLE] : sen_r;
        sys_nxt = (sys_r && !soft_rst) || (addr_perr && pre_r) || perr_seen || tabt_ev; // RULE_10
        // system flag still stands on the reset edge, so the reset must win
        halted_nxt = !soft_rst && (halted_r || serr_drv); // RULE_12
        stat_ev = 5'h00;
        stat_ev[`PEDA_ST_PAR] = data_perr_m || data_perr_s;
        stat_ev[`PEDA_ST_SYS] = (addr_perr && pre_r) || perr_seen || tabt_ev;
        stat_ev[`PEDA_ST_MAB] = mabt_ev;
        stat_ev[`PEDA_ST_TAB] = slv_target_abort; // RULE_19
        if (wr_acc && paddr == `PEDA_OFF_STAT_SET) begin
            stat_ev = stat_ev | pwdata[4:0];
        end
        stat_nxt = stat_ev | stat_r;
        if (wr_acc && paddr == `PEDA_OFF_STAT_CLR) begin
            stat_nxt = stat_ev | (stat_r & ~pwdata[4:0]);
        end
        hien_nxt = (wr_acc && paddr == `PEDA_OFF_HOST_EN) ? pwdata[4:0] : hien_r;
        lien_nxt = (wr_acc && paddr == `PEDA_OFF_LOCAL_EN) ? pwdata[4:0] : lien_r;
        local_int_nxt = |(stat_r & lien_r); // RULE_20
        // error line is asserted one link edge past the faulty phase and held for two link edges
        perr_cnt_nxt = perr_cnt_r;
        if ((data_perr_m || data_perr_s) && pre_r) begin // RULE_08
            perr_cnt_nxt = `PEDA_PERR_HOLD;
        end else if (pe && perr_cnt_r != 2'h0) begin
            perr_cnt_nxt = perr_cnt_r - 2'h1;
        end
        prdata_nxt = prdata_r;
        if (psel && !penable) begin
            case (paddr)
                `PEDA_OFF_CSR, `PEDA_OFF_MIRROR: prdata_nxt = csr_rd;
                `PEDA_OFF_STAT_SET, `PEDA_OFF_STAT_CLR: prdata_nxt = {27'h0, stat_r};
                `PEDA_OFF_HOST_EN: prdata_nxt = {27'h0, hien_r};
                `PEDA_OFF_LOCAL_EN: prdata_nxt = {27'h0, lien_r};
                `PEDA_OFF_CTRL: prdata_nxt = {29'h0, mst_busy, halted_r, 1'b0};
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin // RULE_22
            flg_r <= `PEDA_FLG_RST;
            stat_r <= `PEDA_STAT_RST;
            hien_r <= 5'h00;
            lien_r <= 5'h00;
            pre_r <= 1'b0;
            sen_r <= 1'b0;
            sys_r <= 1'b0;
            halted_r <= 1'b0;
            perr_cnt_r <= 2'h0;
            prdata_r <= 32'h0;
            local_int_r <= 1'b0;
            clk_q_r <= 1'b0;
            ad_p_r <= 32'h0;
            cbe_p_r <= 4'h0;
            frame_p_r <= 1'b0;
            frame_pp_r <= 1'b0;
            dph_p_r <= 1'b0;
            mrd_p_r <= 1'b0;
            swr_p_r <= 1'b0;
        end else begin
            flg_r <= flg_nxt;
            stat_r <= stat_nxt;
            hien_r <= hien_nxt;
            lien_r <= lien_nxt;
            pre_r <= pre_nxt;
            sen_r <= sen_nxt;
            sys_r <= sys_nxt;
            halted_r <= halted_nxt;
            perr_cnt_r <= perr_cnt_nxt;
            prdata_r <= prdata_nxt;
            local_int_r <= local_int_nxt;
            clk_q_r <= clk_s;
            if (pe) begin
                ad_p_r <= ad_s;
                cbe_p_r <= cbe_s;
                frame_p_r <= frame_s;
                frame_pp_r <= frame_p_r;
                dph_p_r <= irdy_s && trdy_s;
                mrd_p_r <= mastering && !wr_r;
                swr_p_r <= slv_active && slv_write;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign frame_line_out_n = ~frame_r;
    assign frame_line_oe = st_r == peda_pkg::PEDA_M_ADDR || mastering;
    assign initiator_ready_line_out_n = ~irdy_r;
    assign initiator_ready_line_oe = mastering || st_r == peda_pkg::PEDA_M_TURN;
    assign parity_error_line_oe = perr_cnt_r != 2'h0 && pre_r && flg_r[`PEDA_FLG_DPE]; // RULE_07
    assign parity_error_line_out_n = 1'b0;
    assign system_error_line_oe = serr_drv;
    assign system_error_line_out_n = 1'b0;
    assign inta_line_oe = |(stat_r & hien_r); // RULE_20
    assign inta_line_out_n = 1'b0;
    assign mst_ready = rdy_r;
    assign mst_done = done_r;
    assign mst_busy = st_r != peda_pkg::PEDA_M_IDLE;
    assign mst_cur_addr = addr_r;
    assign local_int = local_int_r;

    property p_perr_gate;
        @(posedge pclk) disable iff (!presetn)
        parity_error_line_oe |-> pre_r && flg_r[`PEDA_FLG_DPE];
    endproperty
    a_perr_gate: assert property (p_perr_gate) else $error("perr driven without enables"); // RULE_07

    property p_perr_hold;
        @(posedge pclk) disable iff (!presetn)
        $rose(parity_error_line_oe) && pre_r |-> (perr_cnt_r == 2'h2) ##1 (perr_cnt_r != 2'h0)[*2];
    endproperty
    a_perr_hold: assert property (p_perr_hold) else $error("perr hold too short"); // RULE_08

    property p_serr_gate;
        @(posedge pclk) disable iff (!presetn)
        system_error_line_oe |-> sen_r && sys_r;
    endproperty
    a_serr_gate: assert property (p_serr_gate) else $error("serr driven without enable"); // RULE_11

    property p_serr_halt;
        @(posedge pclk) disable iff (!presetn)
        system_error_line_oe && !soft_rst |=> halted_r && flg_r[`PEDA_FLG_SSE];
    endproperty
    a_serr_halt: assert property (p_serr_halt) else $error("serr without halt or flag"); // RULE_12

    property p_mabt_flag;
        @(posedge pclk) disable iff (!presetn)
        mabt_ev |=> flg_r[`PEDA_FLG_RMA] && !frame_r && irdy_r && st_r == peda_pkg::PEDA_M_LAST;
    endproperty
    a_mabt_flag: assert property (p_mabt_flag) else $error("master abort mishandled"); // RULE_15

    property p_tabt_sys;
        @(posedge pclk) disable iff (!presetn)
        tabt_ev |=> sys_r && flg_r[`PEDA_FLG_RTA] && abt_r;
    endproperty
    a_tabt_sys: assert property (p_tabt_sys) else $error("target abort not flagged"); // RULE_10

    property p_unaligned;
        @(posedge pclk) disable iff (!presetn)
        st_r == peda_pkg::PEDA_M_IDLE && mst_addr[1:0] != 2'h0 |=> st_r == peda_pkg::PEDA_M_IDLE;
    endproperty
    a_unaligned: assert property (p_unaligned) else $error("unaligned master start"); // RULE_04

    property p_reissue;
        @(posedge pclk) disable iff (!presetn)
        st_r == peda_pkg::PEDA_M_TURN && pe && cnt_r != 9'h000 && !halted_r
            |=> st_r == peda_pkg::PEDA_M_ADDR && frame_r && $stable(addr_r) && !mst_done;
    endproperty
    a_reissue: assert property (p_reissue) else $error("retry not reissued"); // RULE_17

    property p_w1c;
        @(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == `PEDA_OFF_CSR && pwdata[`PEDA_CSR_RMA] && !mabt_ev
            |=> !flg_r[`PEDA_FLG_RMA];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared by write one"); // RULE_21
endmodule : peda_core
`default_nettype wire

//--- test/peda_tgt_model.sv
`default_nettype none
module peda_tgt_model (
    input wire logic pci_clk_line,
    input wire logic presetn,
    input wire logic [1:0] mode,
    input wire logic bad_par,
    input wire logic frame_n,
    input wire logic irdy_n,
    output logic devsel_n,
    output logic trdy_n,
    output logic stop_n,
    output logic [31:0] ad,
    output logic par
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] n;
    logic retried;
    logic act;
    assign act = !frame_n || !irdy_n;
    // mode 0 no decode, 1 normal, 2 target abort, 3 one retry then normal
    // released lines idle high as with pull-ups; ad keeps moving so stale data never matches
    always @(negedge pci_clk_line or negedge presetn) begin
        if (!presetn) begin
            {n, retried, devsel_n, trdy_n, stop_n, ad, par} <= {4'h0, 1'b0, 3'h7, 32'h0, 1'b0};
        end else begin
            n <= act ? n + 4'h1 : 4'h0;
            devsel_n <= !(act && mode != 2'h0 && !(mode == 2'h2 && n > 4'h1));
            trdy_n <= !(act && n > 4'h0 && (mode == 2'h1 || (mode == 2'h3 && retried)));
            stop_n <= !(act && ((mode == 2'h2 && n > 4'h1) ||
                (mode == 2'h3 && !retried && n > 4'h0)));
            if (!stop_n && mode == 2'h3) begin
                retried <= 1'b1;
            end
            ad <= ad + 32'h1357_9bdf;
            // parity trails its data by one clock; spoil only data phases
            par <= ^ad ^ (bad_par && !trdy_n);
        end
    end
endmodule : peda_tgt_model
`default_nettype wire

//--- test/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn, psel = 0, penable = 0, pwrite = 0, lclk = 0, slv_ta = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, cur_addr, ad, maddr = 32'h0000_0100;
    logic pready, pslverr, err, frame_out_n, frame_oe, irdy_out_n, irdy_oe, perr_oe, serr_oe;
    logic inta_oe, mst_req = 0, mst_ready, mst_done, mst_busy, local_int, bad = 0, perr_seen = 0;
    logic devsel_n, trdy_n, stop_n, par, frame_n, irdy_n;
    logic [8:0] words = 9'h0;
    logic [1:0] mode = 2'h0;
    int mismatches = 0, num_checks = 0, n;
    always #4 pclk = ~pclk;
    always #80 lclk = ~lclk;
    always @(posedge pclk) if (perr_oe) perr_seen <= 1'b1;
    assign frame_n = frame_oe ? frame_out_n : 1'b1;
    assign irdy_n = irdy_oe ? irdy_out_n : 1'b1;
    peda_tgt_model tgt (.pci_clk_line(lclk), .presetn(presetn), .mode(mode), .bad_par(bad),
        .frame_n(frame_n), .irdy_n(irdy_n), .devsel_n(devsel_n), .trdy_n(trdy_n),
        .stop_n(stop_n), .ad(ad), .par(par));
    peda_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pci_clk_line(lclk), .ad_line_in(ad), .cbe_line_in_n(4'h0),
        .par_line_in(par), .frame_line_in_n(frame_n), .initiator_ready_line_in_n(irdy_n),
        .target_ready_line_in_n(trdy_n), .stop_line_in_n(stop_n), .devsel_line_in_n(devsel_n),
        .parity_error_line_in_n(!perr_oe), .frame_line_out_n(frame_out_n),
        .frame_line_oe(frame_oe), .initiator_ready_line_out_n(irdy_out_n),
        .initiator_ready_line_oe(irdy_oe), .parity_error_line_out_n(),
        .parity_error_line_oe(perr_oe), .system_error_line_out_n(),
        .system_error_line_oe(serr_oe), .inta_line_out_n(), .inta_line_oe(inta_oe),
        .slv_active(1'b0), .slv_write(1'b0), .slv_target_abort(slv_ta), .mst_req(mst_req),
        .mst_addr(maddr), .mst_write(1'b0), .mst_words(words), .mst_ready(mst_ready),
        .mst_done(mst_done), .mst_busy(mst_busy), .mst_cur_addr(cur_addr),
        .local_int(local_int));
    task tally_and_finish;
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task hang(input string nm);
        chk(nm, 32'h1, 32'h0);
        tally_and_finish();
    endtask : hang
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i == 50) hang("apb wait");
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task run(input logic [8:0] w, input logic [1:0] m);
        int i;
        @(posedge pclk);
        {mode, words, mst_req} <= {m, w, 1'b1};
        n = 0;
        i = 0;
        do begin
            @(posedge pclk);
            n += int'(mst_ready);
            i++;
        end while (mst_done !== 1'b1 && i < 4000);
        if (i == 4000) hang("master wait");
        mst_req <= 1'b0;
    endtask : run
    task s_regs;
        apb(0, 8'h00, 0); chk("csr reset", 32'h0, rd);
        apb(0, 8'h1c, 0); chk("unmapped err", 32'h1, 32'(err));
        apb(1, 8'h00, 32'h0000_0140); apb(1, 8'h08, 32'h1);
        apb(1, 8'h10, 32'h1); apb(1, 8'h14, 32'h1);
        apb(0, 8'h04, 0); chk("mirror", 32'h140, rd);
        chk("host int", 32'h1, 32'(inta_oe)); chk("local int", 32'h1, 32'(local_int));
        apb(1, 8'h0c, 32'h1); apb(0, 8'h08, 0); chk("status clr", 32'h0, rd);
        @(posedge pclk) slv_ta <= 1'b1;
        @(posedge pclk) slv_ta <= 1'b0;
        {maddr, words, mst_req} <= {32'h0000_0102, 9'h001, 1'b1};
        repeat (60) @(posedge pclk) if (mst_busy !== 1'b0) chk("unaligned", 0, 1);
        {maddr, mst_req} <= {32'h0000_0100, 1'b0};
    endtask : s_regs
    task s_mabort;
        run(9'h4, 2'h0); chk("ma readys", 4, n);
        apb(0, 8'h00, 0); chk("csr rma", 32'h1, 32'(rd[29]));
        apb(0, 8'h04, 0); chk("mir rma", 32'h1, 32'(rd[29]));
        chk("serr off", 32'h0, 32'(serr_oe));
        apb(0, 8'h08, 0); chk("status", 32'h18, rd);
        apb(1, 8'h00, 32'hff00_0140); apb(0, 8'h00, 0); chk("w1c", 32'h140, rd);
    endtask : s_mabort
    task s_retry_par;
        run(9'h3, 2'h3); chk("retry readys", 3, n);
        chk("cur addr", 32'h0000_010c, cur_addr);
        bad <= 1'b1;
        run(9'h2, 2'h1); chk("par readys", 2, n);
        bad <= 1'b0;
        chk("perr seen", 32'h1, 32'(perr_seen));
        apb(0, 8'h00, 0); chk("par flags", 32'h8100_0140, rd);
        apb(1, 8'h00, 32'h8100_0140);
    endtask : s_retry_par
    task s_tabort;
        run(9'h4, 2'h2); chk("ta readys", 4, n);
        chk("serr on", 32'h1, 32'(serr_oe));
        apb(0, 8'h00, 0); chk("ta flags", 32'h5000_0140, rd);
        apb(0, 8'h08, 0); chk("status", 32'h1e, rd);
        apb(0, 8'h18, 0); chk("halted", 32'h1, 32'(rd[1]));
        mst_req <= 1'b1;
        repeat (60) @(posedge pclk) if (mst_busy !== 1'b0) chk("halt busy", 0, 1);
        mst_req <= 1'b0;
        apb(1, 8'h18, 32'h1); apb(0, 8'h18, 0); chk("soft rst", 32'h0, 32'(rd[1]));
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 0); chk("hw rst", 32'h0, rd);
    endtask : s_tabort
    initial begin
        // x to 0 gives every async reset, the model's too, a real edge
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_mabort();
        s_retry_par();
        s_tabort();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
